// *** fmt_regs.svh ***
// register offsets, reset values, field positions and codes of the output formatter
`ifndef FMT_REGS_SVH
`define FMT_REGS_SVH
`define OFS_TRAIN 8'h82
`define OFS_MARKER 8'h83
`define OFS_BLACK 8'h84
`define OFS_IMAGE 8'h85
`define OFS_CHECK 8'h86
`define OFS_TRCLS 8'h87
`define OFS_CTRL 8'h88
`define OFS_STAT 8'h89
`define RST_TRAIN 10'h3a6
`define RST_MARKER 7'h2a
`define RST_BLACK 10'h015
`define RST_IMAGE 10'h035
`define RST_CHECK 10'h059
`define RST_TRCLS 10'h3a6
`define RST_CTRL 5'h00
`define CTRL_MODE8 0
`define CTRL_SEED 1
`define CTRL_SUB 2
`define CTRL_COLOR 3
`define CTRL_PAR 4
`define KIND_FRAME_BEGIN 3'h5
`define KIND_FRAME_FINISH 3'h6
`define KIND_ROW_BEGIN 3'h1
`define KIND_ROW_FINISH 3'h2
`define POLY10 10'h24f
`define POLY8 8'h4d
`define SER_STEPS 3'h1
`define PAR_STEPS 3'h7
`endif

// *** fmt_pkg.sv ***
// types shared by the output formatter files
package fmt_pkg;
  typedef logic [9:0] word_t;
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_begin = 7'h02,
    st_bid = 7'h04,
    st_data = 7'h08,
    st_fin = 7'h10,
    st_fid = 7'h20,
    st_check = 7'h40
  } line_state_e;
  typedef struct packed {
    logic [9:0] train;
    logic [6:0] marker;
    logic [9:0] black;
    logic [9:0] image;
    logic [9:0] check;
    logic [9:0] trcls;
    logic [4:0] ctrl;
  } cfg_s;
endpackage

// *** kernel_order_if.sv ***
// kernel pixel selection signals between formatter and orderer
`timescale 1ns/1ps
interface kernel_order_if;
  logic [159:0] kernel;
  logic odd;
  logic sub;
  logic color;
  logic [2:0] slot;
  logic [39:0] ser_pix;
  logic [9:0] par_pix;
  modport ctrl (output kernel, odd, sub, color, slot, input ser_pix, par_pix);
  modport order (input kernel, odd, sub, color, slot, output ser_pix, par_pix);
endinterface

// *** kernel_order.sv ***
// picks kernel pixels for each channel and slot
`timescale 1ns/1ps
module kernel_order (
  kernel_order_if.order io
);
  // ==========================================
  // pixel index of readout position k
  function automatic logic [3:0] pick(input logic [2:0] k, input logic odd, input logic sub,
                                      input logic color);
    if (!sub)
      pick = odd ? {1'b0, 3'h7 - k} : {1'b0, k};
    else if (color)
      pick = {k[2:1], 1'b0, k[0]};
    else
      pick = {k, 1'b0};
  endfunction

  // ==========================================
  // four serial channels, two pixels each
  genvar c;
  generate
    for (c = 0; c < 4; c++)
    begin : g_ch
      assign io.ser_pix[c*10 +: 10] =
        io.kernel[10*pick({2'(c), io.slot[0]}, io.odd, io.sub, io.color) +: 10];
    end
  endgenerate

  assign io.par_pix = io.kernel[10*pick(io.slot, io.odd, io.sub, io.color) +: 10];
endmodule

// *** sensor_output_sync_crc_formatter.sv ***
// sync channel codes, training, per-line crc and kernel ordering of the sensor output
// Operation
// - 8-bit id word: id in 4:2
// - only highest active window id sent
// - 8-bit frame sync drops two lsbs
// - 8-bit class codes use bits 9:2
// - default dark 0x05, picture 0x0d
// - default check 0x16, training 0xe9
// - idle: training data plus training code
// - 10-bit training from own register 0x3a6
// - 8-bit training is bits 9:2
// - each channel sends line crc at end
// - check code exactly during crc words
// - 10-bit crc polynomial x10+x9+x6+x3+x2+x+1
// - crc reseeded per line, seed select
// - 8-bit crc polynomial x8+x6+x3+x2+1
// - crc spans whole line, all windows
// - kernels eight by one, origin bottom-left
// - four channels, two pixels each
// - even kernels ascending, odd descending
// - mono subsample: even pixels of sixteen
// - colour subsample: pixels 0,1,4,5,8,9,12,13
// - parallel: one 10-bit bus, clock, strobes
// - parallel: no window id, no 8-bit
`timescale 1ns/1ps
`include "fmt_regs.svh"
module sensor_output_sync_crc_formatter (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic clk_link,
  input wire logic kernel_valid,
  input wire logic [159:0] kernel_data,
  input wire logic kernel_odd,
  input wire logic line_start,
  input wire logic line_end,
  input wire logic frame_edge,
  input wire logic black_line,
  input wire logic [7:0] win_active,
  output logic [9:0] sync_word,
  output logic [39:0] data_word,
  output logic [9:0] par_data,
  output logic par_clk,
  output logic par_frame_valid,
  output logic par_line_valid
);
  // ==========================================
  // shared decode functions
  function automatic logic [2:0] top_win(input logic [7:0] w);
    top_win = 3'h0;
    for (int i = 0; i < 8; i++)
      if (w[i])
        top_win = 3'(i);
  endfunction

  function automatic fmt_pkg::word_t narrow(input fmt_pkg::word_t w, input logic m8);
    narrow = m8 ? {2'b00, w[9:2]} : w;
  endfunction

  function automatic fmt_pkg::word_t crc_step(input fmt_pkg::word_t c, input fmt_pkg::word_t d,
                                              input logic m8);
    fmt_pkg::word_t r;
    logic fb;
    r = c;
    for (int i = 9; i >= 0; i--)
    begin
      if (!m8)
      begin
        fb = r[9] ^ d[i];
        r = {r[8:0], 1'b0} ^ (fb ? `POLY10 : 10'h000);
      end
      else if (i < 8)
      begin
        fb = r[7] ^ d[i];
        r = {2'b00, r[6:0], 1'b0} ^ {2'b00, (fb ? `POLY8 : 8'h00)};
      end
    end
    crc_step = r;
  endfunction

  // ==========================================
  // configuration registers
  fmt_pkg::cfg_s regs_q;
  fmt_pkg::cfg_s shadow_q;
  logic pend_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_q;
  logic fv_s1_q;
  logic fv_s2_q;
  logic launch;

  assign launch = pend_q && (req_q == ack_s2_q);

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      regs_q <= '{`RST_TRAIN, `RST_MARKER, `RST_BLACK, `RST_IMAGE, `RST_CHECK, `RST_TRCLS,
                  `RST_CTRL};
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `OFS_TRAIN: regs_q.train <= reg_wdata[9:0];
        `OFS_MARKER: regs_q.marker <= reg_wdata[6:0];
        `OFS_BLACK: regs_q.black <= reg_wdata[9:0];
        `OFS_IMAGE: regs_q.image <= reg_wdata[9:0];
        `OFS_CHECK: regs_q.check <= reg_wdata[9:0];
        `OFS_TRCLS: regs_q.trcls <= reg_wdata[9:0];
        `OFS_CTRL: regs_q.ctrl <= reg_wdata[4:0];
        default: regs_q <= regs_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else
    begin
      case (reg_addr)
        `OFS_TRAIN: reg_rdata <= {6'h00, regs_q.train};
        `OFS_MARKER: reg_rdata <= {9'h000, regs_q.marker};
        `OFS_BLACK: reg_rdata <= {6'h00, regs_q.black};
        `OFS_IMAGE: reg_rdata <= {6'h00, regs_q.image};
        `OFS_CHECK: reg_rdata <= {6'h00, regs_q.check};
        `OFS_TRCLS: reg_rdata <= {6'h00, regs_q.trcls};
        `OFS_CTRL: reg_rdata <= {11'h000, regs_q.ctrl};
        `OFS_STAT: reg_rdata <= {14'h0000, pend_q | (req_q != ack_s2_q), fv_s2_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ==========================================
  // configuration handshake toward link
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pend_q <= 1'b0;
      req_q <= 1'b0;
      shadow_q <= '{`RST_TRAIN, `RST_MARKER, `RST_BLACK, `RST_IMAGE, `RST_CHECK, `RST_TRCLS,
                    `RST_CTRL};
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      fv_s1_q <= 1'b0;
      fv_s2_q <= 1'b0;
    end
    else
    begin
      pend_q <= reg_wr ? 1'b1 : (launch ? 1'b0 : pend_q);
      if (launch)
      begin
        shadow_q <= regs_q;
        req_q <= ~req_q;
      end
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      fv_s1_q <= par_frame_valid;
      fv_s2_q <= fv_s1_q;
    end
  end

  // ==========================================
  // link domain reset and configuration
  logic lrst1_q;
  logic lrst_n;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  fmt_pkg::cfg_s cfg_q;
  logic m8;
  logic par;

  always_ff @(posedge clk_link)
  begin
    lrst1_q <= resetn;
    lrst_n <= lrst1_q;
  end

  always_ff @(posedge clk_link)
  begin
    if (!lrst_n)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_q <= 1'b0;
      cfg_q <= '{`RST_TRAIN, `RST_MARKER, `RST_BLACK, `RST_IMAGE, `RST_CHECK, `RST_TRCLS,
                 `RST_CTRL};
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_s2_q != req_s3_q)
      begin
        cfg_q <= shadow_q;
        ack_q <= req_s2_q;
      end
    end
  end

  assign par = cfg_q.ctrl[`CTRL_PAR];
  assign m8 = cfg_q.ctrl[`CTRL_MODE8] && !par;

  // ==========================================
  // line sequencer
  fmt_pkg::line_state_e st_q;
  logic first_q;
  logic last_q;
  logic black_q;
  logic [2:0] win_q;

  always_ff @(posedge clk_link)
  begin
    if (!lrst_n)
    begin
      st_q <= fmt_pkg::st_idle;
      first_q <= 1'b0;
      last_q <= 1'b0;
      black_q <= 1'b0;
      win_q <= 3'h0;
    end
    else
    begin
      case (st_q)
        fmt_pkg::st_idle:
          if (line_start)
          begin
            st_q <= fmt_pkg::st_begin;
            first_q <= frame_edge;
            black_q <= black_line;
            win_q <= top_win(win_active);
          end
        fmt_pkg::st_begin: st_q <= fmt_pkg::st_bid;
        fmt_pkg::st_bid: st_q <= fmt_pkg::st_data;
        fmt_pkg::st_data:
          if (line_end)
          begin
            st_q <= fmt_pkg::st_fin;
            last_q <= frame_edge;
          end
        fmt_pkg::st_fin: st_q <= fmt_pkg::st_fid;
        fmt_pkg::st_fid: st_q <= fmt_pkg::st_check;
        fmt_pkg::st_check: st_q <= fmt_pkg::st_idle;
        default: st_q <= fmt_pkg::st_idle;
      endcase
    end
  end

  // ==========================================
  // kernel stepping
  kernel_order_if ko ();
  logic [159:0] kern_q;
  logic odd_q;
  logic [2:0] step_q;
  logic kbusy_q;
  logic [2:0] last_step;

  assign last_step = par ? `PAR_STEPS : `SER_STEPS;

  always_ff @(posedge clk_link)
  begin
    if (!lrst_n)
    begin
      kern_q <= '0;
      odd_q <= 1'b0;
      step_q <= 3'h0;
      kbusy_q <= 1'b0;
    end
    else if (kernel_valid && st_q == fmt_pkg::st_data)
    begin
      kern_q <= kernel_data;
      odd_q <= kernel_odd;
      step_q <= 3'h0;
      kbusy_q <= 1'b1;
    end
    else if (kbusy_q)
    begin
      step_q <= step_q + 3'h1;
      kbusy_q <= step_q != last_step;
    end
  end

  assign ko.kernel = kern_q;
  assign ko.odd = odd_q;
  assign ko.sub = cfg_q.ctrl[`CTRL_SUB];
  assign ko.color = cfg_q.ctrl[`CTRL_COLOR];
  assign ko.slot = step_q;

  kernel_order u_order (
    .io(ko.order)
  );

  // ==========================================
  // sync channel word
  fmt_pkg::word_t sync_d;
  logic [2:0] kind;

  always_comb
  begin
    kind = first_q ? `KIND_FRAME_BEGIN : `KIND_ROW_BEGIN;
    sync_d = narrow(cfg_q.trcls, m8);
    case (st_q)
      fmt_pkg::st_begin:
        sync_d = m8 ? {2'b00, kind, cfg_q.marker[6:2]} : {kind, cfg_q.marker};
      fmt_pkg::st_fin:
        sync_d = m8 ? {2'b00, (last_q ? `KIND_FRAME_FINISH : `KIND_ROW_FINISH),
                       cfg_q.marker[6:2]}
                    : {(last_q ? `KIND_FRAME_FINISH : `KIND_ROW_FINISH), cfg_q.marker};
      fmt_pkg::st_bid, fmt_pkg::st_fid:
        sync_d = m8 ? {5'h00, win_q, 2'b00} : {7'h00, win_q};
      fmt_pkg::st_data:
        sync_d = narrow(black_q ? cfg_q.black : cfg_q.image, m8);
      fmt_pkg::st_check: sync_d = narrow(cfg_q.check, m8);
      default: sync_d = narrow(cfg_q.trcls, m8);
    endcase
  end

  // ==========================================
  // per-channel data and crc
  fmt_pkg::word_t crc_q [4];
  fmt_pkg::word_t word_in [4];
  logic [39:0] data_d;
  fmt_pkg::word_t train_w;

  assign train_w = narrow(cfg_q.train, m8);

  genvar c;
  generate
    for (c = 0; c < 4; c++)
    begin : g_crc
      assign word_in[c] = narrow((par && c == 0) ? ko.par_pix : ko.ser_pix[c*10 +: 10], m8);
      always_ff @(posedge clk_link)
      begin
        if (!lrst_n)
          crc_q[c] <= 10'h000;
        else if (st_q == fmt_pkg::st_begin)
          crc_q[c] <= cfg_q.ctrl[`CTRL_SEED] ? (m8 ? 10'h0ff : 10'h3ff) : 10'h000;
        else if (st_q == fmt_pkg::st_data && kbusy_q)
          crc_q[c] <= crc_step(crc_q[c], word_in[c], m8);
      end
      assign data_d[c*10 +: 10] = (st_q == fmt_pkg::st_check) ? crc_q[c] :
                                  (st_q == fmt_pkg::st_data && kbusy_q) ? word_in[c] : train_w;
    end
  endgenerate

  // ==========================================
  // output registers
  always_ff @(posedge clk_link)
  begin
    if (!lrst_n)
    begin
      sync_word <= `RST_TRCLS;
      data_word <= {4{`RST_TRAIN}};
      par_data <= 10'h000;
      par_clk <= 1'b0;
      par_frame_valid <= 1'b0;
      par_line_valid <= 1'b0;
    end
    else
    begin
      sync_word <= sync_d;
      data_word <= data_d;
      par_data <= par ? data_d[9:0] : 10'h000;
      par_clk <= ~par_clk;
      par_line_valid <= par && st_q == fmt_pkg::st_data && kbusy_q;
      if (par && st_q == fmt_pkg::st_begin && first_q)
        par_frame_valid <= 1'b1;
      else if (st_q == fmt_pkg::st_check && last_q)
        par_frame_valid <= 1'b0;
    end
  end

  // ==========================================
  // checks
  id_word_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_bid && m8) |=> sync_word == {5'h00, win_q, 2'b00})
    else $error("window id word malformed");
  top_win_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_idle && line_start && win_active != 8'h00)
    |=> ($past(win_active) >> win_q) == 8'h01)
    else $error("window id not highest");
  sync_lsb_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_begin && m8) |=> sync_word[4:0] == cfg_q.marker[6:2]
    && sync_word[9:8] == 2'b00)
    else $error("8-bit frame sync wrong");
  class_8bit_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_data && m8 && black_q) |=> sync_word == {2'b00, cfg_q.black[9:2]})
    else $error("8-bit class code wrong");
  idle_train_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_idle) |=> data_word[39:30] == $past(train_w)
    && sync_word == $past(narrow(cfg_q.trcls, m8)))
    else $error("idle not training");
  check_align_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_check) |=> sync_word == narrow(cfg_q.check, m8)
    && data_word[9:0] == $past(crc_q[0]))
    else $error("crc and check code misaligned");
  crc_seed_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_begin && !cfg_q.ctrl[`CTRL_SEED]) |=> crc_q[1] == 10'h000)
    else $error("crc seed wrong");
  after_crc_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    (st_q == fmt_pkg::st_check) |=> ##1 data_word[19:10] == $past(train_w))
    else $error("no training after crc");
  par_no8_a: assert property (@(posedge clk_link) disable iff (!lrst_n)
    par |-> !m8)
    else $error("8-bit active on parallel");
  line_cov_c: cover property (@(posedge clk_link) disable iff (!lrst_n)
    st_q == fmt_pkg::st_check);
  mode8_cov_c: cover property (@(posedge clk_link) disable iff (!lrst_n)
    m8 && st_q == fmt_pkg::st_data && kbusy_q);
  par_cov_c: cover property (@(posedge clk_link) disable iff (!lrst_n) par_line_valid);
endmodule

// *** line_receiver.sv ***
// receiver model of the sync and data channels: crc reference and check word capture
`timescale 1ns/1ps
module line_receiver (
  input wire logic clk_link,
  input wire logic resetn,
  input wire logic [9:0] sync_word,
  input wire logic [39:0] data_word,
  input wire logic [9:0] check_code,
  output logic [39:0] crc_seen,
  output logic [7:0] check_hits
);
  // ==========
  // crc reference
  // seed select
  function automatic logic [9:0] seed_of(input logic ones, input logic m8);
    seed_of = ones ? (m8 ? 10'h0ff : 10'h3ff) : 10'h000;
  endfunction
  // one word per step, msb first
  function automatic logic [9:0] crc_word(input logic [9:0] crc, input logic [9:0] w,
                                          input logic m8);
    logic [9:0] c;
    logic fb;
    c = crc;
    for (int i = m8 ? 7 : 9; i >= 0; i--)
    begin
      fb = (m8 ? c[7] : c[9]) ^ w[i];
      c = {c[8:0], 1'b0};
      if (m8)
        c = {2'b00, c[7:0] ^ (fb ? 8'h4d : 8'h00)};
      else
        c = c ^ (fb ? 10'h24f : 10'h000);
    end
    crc_word = c;
  endfunction
  // ==========
  // check word capture
  // crc words ride with the check code
  always_ff @(posedge clk_link)
  begin
    if (!resetn)
    begin
      crc_seen <= 40'h0;
      check_hits <= 8'h00;
    end
    else if (sync_word == check_code)
    begin
      crc_seen <= data_word;
      check_hits <= check_hits + 8'h01;
    end
  end
endmodule

// *** sensor_output_sync_crc_formatter_test.sv ***
// self-checking bench of the sync, crc and kernel order formatter
`timescale 1ns/1ps
module sensor_output_sync_crc_formatter_test;
  localparam int NK = 3;
  logic clk_sys, resetn, reg_wr, clk_link, kernel_valid, kernel_odd;
  logic line_start, line_end, frame_edge, black_line, par_clk, par_frame_valid, par_line_valid;
  logic [7:0] reg_addr, win_active, check_hits;
  logic [15:0] reg_wdata, reg_rdata;
  logic [159:0] kernel_data;
  logic [9:0] sync_word, par_data, check_code, train_v, check_v;
  logic [39:0] data_word, crc_seen;
  int failures, comparisons;
  sensor_output_sync_crc_formatter sensor_output_sync_crc_formatter_inst (.clk_sys(clk_sys),
    .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .clk_link(clk_link), .kernel_valid(kernel_valid),
    .kernel_data(kernel_data), .kernel_odd(kernel_odd), .line_start(line_start),
    .line_end(line_end), .frame_edge(frame_edge), .black_line(black_line),
    .win_active(win_active), .sync_word(sync_word), .data_word(data_word),
    .par_data(par_data), .par_clk(par_clk), .par_frame_valid(par_frame_valid),
    .par_line_valid(par_line_valid));
  line_receiver line_receiver_inst (.clk_link(clk_link), .resetn(resetn),
    .sync_word(sync_word), .data_word(data_word), .check_code(check_code),
    .crc_seen(crc_seen), .check_hits(check_hits));
  // ==========
  // clocks
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_link = 1'b0;
    #7;
    forever #16 clk_link = ~clk_link;
  end
  // ==========
  // helpers
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    @(posedge clk_sys);
    #1;
    check({24'h0, reg_rdata}, {24'h0, exp});
  endtask
  function automatic int pick(input int k, input logic [4:0] ctrl, input logic odd);
    if (ctrl[2])
      return ctrl[3] ? (k / 2) * 4 + k % 2 : 2 * k;
    return odd ? 7 - k : k;
  endfunction
  function automatic logic [9:0] top_id(input logic [7:0] w);
    top_id = 10'h000;
    for (int i = 0; i < 8; i++)
      if (w[i])
        top_id = 10'(i);
  endfunction
  function automatic logic [9:0] cls(input logic [9:0] v, input logic m8);
    cls = m8 ? {2'b00, v[9:2]} : v;
  endfunction
  // ==========
  // one line with NK kernels
  task automatic run_line(input logic [4:0] ctrl, input logic fb, input logic ff,
                          input logic blk);
    logic m8;
    logic [9:0] crc [4];
    logic [9:0] tr;
    logic [159:0] kd [NK];
    logic [7:0] win;
    logic [7:0] hits;
    int ln, i;
    m8 = ctrl[0];
    win = 8'($urandom) | 8'h01;
    tr = cls(train_v, m8);
    for (int c = 0; c < 4; c++)
      crc[c] = line_receiver_inst.seed_of(ctrl[1], m8);
    check_code = cls(check_v, m8);
    ln = 6 + 2 * NK;
    hits = check_hits;
    @(posedge clk_link);
    line_start <= 1'b1;
    frame_edge <= fb;
    black_line <= blk;
    win_active <= win;
    for (int n = 0; n <= ln + 5; n++)
    begin
      @(posedge clk_link);
      line_start <= (n == 4);
      line_end <= (n + 1 == ln);
      frame_edge <= (n + 1 == ln) ? ff : 1'b0;
      kernel_valid <= (n >= 3 && n % 2 == 1 && n < 3 + 2 * NK);
      if (n >= 3 && n % 2 == 1 && n < 3 + 2 * NK)
      begin
        kd[(n - 3) / 2] = {$urandom, $urandom, $urandom, $urandom, $urandom};
        kernel_data <= kd[(n - 3) / 2];
        kernel_odd <= (n % 4 == 1);
      end
      #1;
      if (n == 1)
        check({30'h0, sync_word}, {30'h0, cls({fb ? 3'h5 : 3'h1, 7'h2a}, m8)});
      else if (n == 2 || n == ln + 2)
        check({30'h0, sync_word}, {30'h0, m8 ? top_id(win) << 2 : top_id(win)});
      else if (n >= 3 && n <= ln)
        check({30'h0, sync_word}, {30'h0, cls(blk ? 10'h015 : 10'h035, m8)});
      else if (n == ln + 1)
        check({30'h0, sync_word}, {30'h0, cls({ff ? 3'h6 : 3'h2, 7'h2a}, m8)});
      else if (n == ln + 3)
        check({30'h0, sync_word}, {30'h0, check_code});
      else if (n == ln + 4)
      begin
        check({30'h0, sync_word}, {30'h0, cls(10'h3a6, m8)});
        check(data_word, {tr, tr, tr, tr});
        check({29'h0, par_line_valid, par_data}, 40'h0);
      end
      if (n >= 5 && n < 5 + 2 * NK)
      begin
        i = (n - 5) / 2;
        for (int c = 0; c < 4; c++)
        begin
          if (!m8)
            check({30'h0, data_word[10 * c +: 10]},
                  {30'h0, kd[i][10 * pick(2 * c + (n + 1) % 2, ctrl, i % 2 == 1) +: 10]});
          crc[c] = line_receiver_inst.crc_word(crc[c], data_word[10 * c +: 10], m8);
        end
      end
    end
    check({32'h0, check_hits - hits}, 40'h1);
    for (int c = 0; c < 4; c++)
      check({30'h0, crc_seen[10 * c +: 10]}, {30'h0, crc[c]});
  endtask
  // ==========
  // one parallel line with one kernel, 8-bit asked for but full words expected
  // receiver takes 10-bit words
  task automatic par_line();
    logic [159:0] kd;
    logic [9:0] crc;
    logic odd;
    logic pc;
    crc = line_receiver_inst.seed_of(1'b0, 1'b0);
    kd = {$urandom, $urandom, $urandom, $urandom, $urandom};
    odd = 1'($urandom);
    pc = 1'b0;
    @(posedge clk_link);
    line_start <= 1'b1;
    frame_edge <= 1'b1;
    for (int n = 0; n <= 17; n++)
    begin
      @(posedge clk_link);
      line_start <= 1'b0;
      kernel_valid <= (n == 2);
      kernel_data <= kd;
      kernel_odd <= odd;
      line_end <= (n == 11);
      frame_edge <= (n == 11);
      #1;
      if (n > 0)
        check({39'h0, par_clk}, {39'h0, ~pc});
      pc = par_clk;
      if (n >= 4 && n <= 11)
      begin
        check({29'h0, par_line_valid, par_data},
              {29'h0, 1'b1, kd[10 * pick(n - 4, 5'h11, odd) +: 10]});
        crc = line_receiver_inst.crc_word(crc, par_data, 1'b0);
      end
      if (n == 3)
        check({39'h0, par_frame_valid}, 40'h1);
      if (n == 15)
        check({30'h0, par_data}, {30'h0, crc});
      if (n == 16)
        check({38'h0, par_frame_valid, par_line_valid}, 40'h0);
    end
  endtask
  // ==========
  // main sequence
  logic [4:0] ctl [5] = '{5'h00, 5'h01, 5'h06, 5'h0c, 5'h03};
  logic [15:0] rst_v [8] = '{16'h03a6, 16'h002a, 16'h0015, 16'h0035, 16'h0059, 16'h03a6,
                             16'h0000, 16'h0000};
  initial
  begin
    failures = 0;
    comparisons = 0;
    resetn = 1'b0;
    {reg_wr, kernel_valid, kernel_odd, line_start, line_end, frame_edge, black_line} = '0;
    reg_addr = 8'h82;
    reg_wdata = 16'h0000;
    win_active = 8'h01;
    kernel_data = '0;
    check_code = 10'h059;
    train_v = 10'h3a6;
    check_v = 10'h059;
    void'($urandom(24));
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++)
      reg_read(a == 7 ? 8'h90 : 8'h82 + 8'(a), rst_v[a]);
    reg_write(8'h90, 16'hffff);
    reg_read(8'h90, 16'h0000);
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 5; m++)
      begin
        reg_write(8'h88, {11'h0, ctl[m]});
        if (m == 2)
        begin
          train_v = 10'($urandom);
          reg_write(8'h82, {6'h3f, train_v});
          reg_read(8'h82, {6'h0, train_v});
        end
        if (m == 4)
        begin
          check_v = {3'b011, 7'($urandom)};
          reg_write(8'h86, {6'h00, check_v});
        end
        repeat (30) @(posedge clk_link);
        run_line(ctl[m], m == 0, m == 3, m == 1 || m == 2);
      end
    reg_write(8'h88, 16'h0011);
    repeat (30) @(posedge clk_link);
    par_line();
    close_out();
  end
  initial
  begin
    #500000;
    failures++;
    close_out();
  end
endmodule
